// >>> bus_master_ctrl.sv
/*
 * two-wire bus master controller with an AXI4-Lite register slave.
 * assumes software sequences start, bytes and stop; sda passes two flops.
 */
`timescale 1ns/1ps
module bus_master_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	two_wire_if.master bus,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	function automatic logic mapped(input logic [7:0] a);
		return a == eeprom_pkg::CMD_OFFSET || a == eeprom_pkg::TX_OFFSET ||
			a == eeprom_pkg::RX_OFFSET || a == eeprom_pkg::STATUS_OFFSET;
	endfunction

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	logic aw_hold;
	logic w_hold;
	logic [7:0] aw_q;
	logic [7:0] wd_q;
	logic ws_q;
	logic do_write;
	logic go;
	logic busy;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic ack_seen;
	eeprom_pkg::master_state_t hst;

	assign awready = !aw_hold && !bvalid;
	assign wready = !w_hold && !bvalid;
	assign arready = !rvalid;
	assign do_write = aw_hold && w_hold && !bvalid;
	assign busy = hst != eeprom_pkg::h_idle;
	// a command while busy is dropped; software polls the busy bit first
	assign go = do_write && aw_q == eeprom_pkg::CMD_OFFSET && ws_q && !busy;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_q <= 8'h00;
			wd_q <= 8'h00;
			ws_q <= 1'b0;
			bvalid <= 1'b0;
			bresp <= eeprom_pkg::RESP_OKAY;
			tx_byte <= 8'h00;
		end else begin
			if (awvalid && awready) begin
				aw_hold <= 1'b1;
				aw_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_hold <= 1'b1;
				wd_q <= wdata[7:0];
				ws_q <= wstrb[0];
			end
			if (do_write) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				bvalid <= 1'b1;
				bresp <= mapped(aw_q) ? eeprom_pkg::RESP_OKAY : eeprom_pkg::RESP_SLVERR;
				if (aw_q == eeprom_pkg::TX_OFFSET && ws_q) begin
					tx_byte <= wd_q;
				end
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= eeprom_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp <= mapped(araddr) ? eeprom_pkg::RESP_OKAY : eeprom_pkg::RESP_SLVERR;
			unique case (araddr)
				eeprom_pkg::TX_OFFSET: rdata <= {24'h000000, tx_byte};
				eeprom_pkg::RX_OFFSET: rdata <= {24'h000000, rx_byte};
				eeprom_pkg::STATUS_OFFSET: rdata <= {30'h0, ack_seen, busy};
				default: rdata <= 32'h0000_0000;
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// bit engine
	// ----------------------------------------
	logic sda_s;
	logic [eeprom_pkg::DIV_W-1:0] div;
	logic [1:0] q;
	logic [3:0] bitn;
	logic [7:0] shf;
	logic do_start;
	logic do_byte;
	logic do_read;
	logic do_stop;
	logic send_nack;
	logic scl;
	logic oe;
	logic tick;

	sync2 #(.W(1)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(bus.sda),
		.q(sda_s)
	);

	assign tick = div == eeprom_pkg::DIV_W'(eeprom_pkg::SCL_QUARTER_CYCLES - 1);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hst <= eeprom_pkg::h_idle;
			div <= '0;
			q <= 2'h0;
			bitn <= 4'h0;
			shf <= 8'h00;
			{do_start, do_byte, do_read, do_stop, send_nack} <= 5'h00;
			scl <= 1'b1;
			oe <= 1'b0;
			rx_byte <= 8'h00;
			ack_seen <= 1'b0;
		end else if (hst == eeprom_pkg::h_idle) begin
			if (go) begin
				hst <= eeprom_pkg::h_pick;
				do_start <= wd_q[eeprom_pkg::CMD_START];
				do_stop <= wd_q[eeprom_pkg::CMD_STOP];
				// one byte per command: page length is counted by software
				do_byte <= wd_q[eeprom_pkg::CMD_WRITE] || wd_q[eeprom_pkg::CMD_READ];
				do_read <= wd_q[eeprom_pkg::CMD_READ];
				send_nack <= wd_q[eeprom_pkg::CMD_NACK];
				shf <= tx_byte;
			end
		end else if (hst == eeprom_pkg::h_pick) begin
			div <= '0;
			q <= 2'h0;
			bitn <= 4'h0;
			if (do_start) begin
				do_start <= 1'b0;
				hst <= eeprom_pkg::h_start;
				oe <= 1'b0;
			end else if (do_byte) begin
				do_byte <= 1'b0;
				hst <= eeprom_pkg::h_byte;
				oe <= !do_read && !shf[7];
			end else if (do_stop) begin
				do_stop <= 1'b0;
				hst <= eeprom_pkg::h_stop;
				oe <= 1'b1;
			end else begin
				hst <= eeprom_pkg::h_idle;
			end
		end else begin
			div <= tick ? '0 : div + 1'b1;
			if (tick) begin
				q <= q + 2'h1;
				unique case (hst)
					eeprom_pkg::h_start: begin
						if (q == 2'h0) scl <= 1'b1;
						if (q == 2'h1) oe <= 1'b1;
						if (q == 2'h2) scl <= 1'b0;
						if (q == 2'h3) hst <= eeprom_pkg::h_pick;
					end
					eeprom_pkg::h_stop: begin
						if (q == 2'h0) scl <= 1'b1;
						if (q == 2'h1) oe <= 1'b0;
						if (q == 2'h3) hst <= eeprom_pkg::h_pick;
					end
					default: begin
						if (q == 2'h0) scl <= 1'b1;
						if (q == 2'h1) begin
							if (bitn < eeprom_pkg::LAST_BIT) begin
								shf <= {shf[6:0], sda_s};
							end else if (!do_read) begin
								ack_seen <= !sda_s;
							end
						end
						if (q == 2'h2) scl <= 1'b0;
						if (q == 2'h3) begin
							// data changes only in the low quarter
							bitn <= bitn + 4'h1;
							if (bitn == 4'h7) begin
								oe <= do_read && !send_nack;
							end else if (bitn == eeprom_pkg::LAST_BIT) begin
								oe <= 1'b0;
								rx_byte <= shf;
								hst <= eeprom_pkg::h_pick;
							end else begin
								oe <= !do_read && !shf[7];
							end
						end
					end
				endcase
			end
		end
	end

	assign bus.scl = scl;
	assign bus.host_sda_oe = oe;

endmodule // bus_master_ctrl

// >>> eeprom_link_chk.sv
/* assertions on the two-wire link between the controller and the eeprom.
   assumes the bench wires the interface signals in as plain inputs. */
`timescale 1ns/1ps
module eeprom_link_chk #(
	parameter int unsigned WRITE_CYCLES = 200
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic scl,
	input wire logic host_sda_oe,
	input wire logic dev_sda_oe,
	input wire logic sda,
	input wire logic supply_ok,
	input wire logic write_busy
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic scl_q, sda_q, start, stop, quiet;
	logic [3:0] rises;
	logic [4:0] since_stop;
	logic [31:0] busy_cnt;
	assign start = scl && scl_q && sda_q && !sda;
	assign stop = scl && scl_q && !sda_q && sda;
	always_ff @(posedge aclk) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// rises saturates at 8 so read bytes keep the device allowed to drive
	always_ff @(posedge aclk) begin
		if (!aresetn || start) rises <= 4'h0;
		else if (scl && !scl_q && rises != 4'h8) rises <= rises + 4'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || stop) since_stop <= 5'h0;
		else if (since_stop != 5'h1f) since_stop <= since_stop + 5'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !write_busy) busy_cnt <= 32'h0;
		else busy_cnt <= busy_cnt + 32'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) quiet <= 1'b0;
		else if (write_busy) quiet <= 1'b1;
		else if (start) quiet <= 1'b0;
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_busy_released: assert property (write_busy |-> !dev_sda_oe)
		else $error("eeprom drives sda while writing");
	chk_change_scl_low: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("eeprom sda changed while scl high");
	chk_stable_high: assert property ($rose(scl) |=> $stable(dev_sda_oe)[*8])
		else $error("eeprom sda not stable after scl rise");
	chk_supply_reset: assert property (!supply_ok[*4] |=> !write_busy && !dev_sda_oe)
		else $error("eeprom active with supply low");
	chk_busy_length: assert property ($fell(write_busy) |-> busy_cnt == WRITE_CYCLES)
		else $error("write cycle length wrong");
	chk_busy_on_stop: assert property ($rose(write_busy) |-> since_stop < 5'h10)
		else $error("write cycle began without stop");
	chk_ack_after_addr: assert property (dev_sda_oe |-> rises == 4'h8)
		else $error("eeprom drove sda before eight bits");
	chk_quiet_until_start: assert property (dev_sda_oe |-> !quiet)
		else $error("eeprom answered without a fresh start");
	// the controller may move sda under a high scl only to frame a transfer
	chk_host_start_stop: assert property ($changed(host_sda_oe) && scl |-> start || stop)
		else $error("controller moved sda while scl high outside start or stop");
endmodule // eeprom_link_chk

// >>> eeprom_pkg.sv
/*
 * shared constants and types for the two-wire serial eeprom slave and the
 * bus master controller that drives it.
 * assumes both ends run on aclk at 250 MHz with a synchronous active-low reset.
 */
// Operation
// - supply above trigger: standby; below: reset
// - sample SDA on SCL rise, drive on fall
// - write-protect high blocks writes; undriven reads low
// - START/STOP by SDA edge while SCL high
// - chip selects match straps; upper bit; rw last
// - acknowledge address, word address, write data
// - read: release ninth clock, master ends nack
// - write: address, byte address, data; STOP commits
// - busy writing: SDA released, no response
// - up to 16 bytes, one write cycle
// - write increments only low four address bits
// - over sixteen bytes wraps, overwrites page buffer
// - poll: no acknowledge while internal write runs
// - strobe write-protect before first data byte
// - read address: acknowledge, send current byte
// - random read: dummy write, repeated START, read
// - sequential read wraps at end of memory
// - byte address loads the address pointer
// - zero pulls low, one releases; stable high
package eeprom_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int WRITE_TIME_NS = 4000000;
	localparam int WRITE_CYCLES = WRITE_TIME_NS / CLK_PERIOD_NS;
	localparam int WRITE_TIMER_W = 20;
	localparam int SCL_QUARTER_NS = 250;
	localparam int SCL_QUARTER_CYCLES = (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIV_W = 7;

	// ----------------------------------------
	// memory and addressing
	// ----------------------------------------
	localparam int MEM_BYTES = 512;
	localparam int PAGE_BYTES = 16;
	localparam logic [3:0] TYPE_CODE = 4'ha;
	localparam logic [7:0] ERASED = 8'hff;
	localparam logic [3:0] LAST_BIT = 4'h8;
	localparam logic [3:0] ACK_BIT = 4'h9;

	// ----------------------------------------
	// controller registers (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] CMD_OFFSET = 8'h00;
	localparam logic [7:0] TX_OFFSET = 8'h04;
	localparam logic [7:0] RX_OFFSET = 8'h08;
	localparam logic [7:0] STATUS_OFFSET = 8'h0c;
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_WRITE = 2;
	localparam int CMD_READ = 3;
	localparam int CMD_NACK = 4;
	localparam int STATUS_BUSY = 0;
	localparam int STATUS_ACK = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {st_idle, st_addr, st_word, st_data, st_read} slave_state_t;
	typedef enum logic [2:0] {h_idle, h_pick, h_start, h_byte, h_stop} master_state_t;

endpackage

// >>> eeprom_slave.sv
/*
 * protocol logic of a 4-kbit two-wire serial eeprom slave with page buffer.
 * assumes an external master makes scl; all pins are asynchronous to aclk
 * and pass two flops first; the bench resolves an undriven wp to low.
 */
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
module eeprom_slave #(
	parameter int unsigned WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	two_wire_if.slave bus,
	input wire logic supply_ok,
	input wire logic wp,
	input wire logic chip_select_low_pin,
	input wire logic chip_select_high_pin,
	output logic write_busy
);

	// ----------------------------------------
	// pin sampling
	// ----------------------------------------
	logic [4:0] pins;
	logic scl_s;
	logic sda_s;
	logic wp_s;
	logic [1:0] cs_s;
	logic power_s;
	logic scl_d;
	logic sda_d;

	sync2 #(.W(5)) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({supply_ok, chip_select_high_pin, chip_select_low_pin, wp, bus.sda}),
		.q(pins)
	);

	// scl also passes two flops; kept apart so edge logic reads only the second
	logic scl_meta;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_meta <= 1'b0;
			scl_s <= 1'b0;
		end else begin
			scl_meta <= bus.scl;
			scl_s <= scl_meta;
		end
	end

	assign sda_s = pins[0];
	assign wp_s = pins[1];
	assign cs_s = pins[3:2];
	assign power_s = pins[4];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			scl_d <= 1'b0;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic in_reset;
	logic start_c;
	logic stop_c;
	logic rise;
	logic fall;

	assign in_reset = !aresetn || !power_s;
	assign start_c = scl_s && scl_d && sda_d && !sda_s;
	assign stop_c = scl_s && scl_d && !sda_d && sda_s;
	assign rise = scl_s && !scl_d;
	assign fall = !scl_s && scl_d;

	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [7:0] mem [eeprom_pkg::MEM_BYTES] = '{default: eeprom_pkg::ERASED};
	logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];
	logic [eeprom_pkg::PAGE_BYTES-1:0] page_vld;

	// ----------------------------------------
	// protocol
	// ----------------------------------------
	eeprom_pkg::slave_state_t state;
	logic [3:0] cnt;
	logic [7:0] shreg;
	logic [7:0] tx;
	logic [8:0] ptr;
	logic rw;
	logic wp_lat;
	logic nack;
	logic pending;
	logic oe;
	logic busy;
	logic commit;
	logic addr_ok;

	assign addr_ok = shreg[7:4] == eeprom_pkg::TYPE_CODE && shreg[3:2] == cs_s && !busy;
	assign commit = stop_c && pending && !busy;

	always_ff @(posedge aclk) begin
		if (in_reset) begin
			state <= eeprom_pkg::st_idle;
			cnt <= 4'h0;
			shreg <= 8'h00;
			tx <= 8'h00;
			ptr <= 9'h000;
			rw <= 1'b0;
			wp_lat <= 1'b0;
			nack <= 1'b0;
			pending <= 1'b0;
			page_vld <= '0;
			oe <= 1'b0;
		end else if (start_c) begin
			// a repeated start keeps the pointer for a random read
			state <= eeprom_pkg::st_addr;
			cnt <= 4'h0;
			oe <= 1'b0;
		end else if (stop_c) begin
			state <= eeprom_pkg::st_idle;
			oe <= 1'b0;
			pending <= 1'b0;
			page_vld <= '0;
		end else if (state != eeprom_pkg::st_idle) begin
			if (rise && cnt < eeprom_pkg::ACK_BIT) begin
				cnt <= cnt + 4'h1;
				if (cnt < eeprom_pkg::LAST_BIT) begin
					shreg <= {shreg[6:0], sda_s};
				end else begin
					nack <= sda_s;
				end
			end
			if (fall) begin
				if (cnt == eeprom_pkg::LAST_BIT) begin
					unique case (state)
						eeprom_pkg::st_addr: begin
							if (addr_ok) begin
								oe <= 1'b1;
								ptr[8] <= shreg[1];
								rw <= shreg[0];
							end else begin
								state <= eeprom_pkg::st_idle;
							end
						end
						eeprom_pkg::st_word: begin
							oe <= 1'b1;
							ptr[7:0] <= shreg;
						end
						eeprom_pkg::st_data: begin
							if (wp_lat) begin
								// protected: withhold acknowledge and drop the whole session
								state <= eeprom_pkg::st_idle;
								pending <= 1'b0;
								page_vld <= '0;
							end else begin
								oe <= 1'b1;
								page_buf[ptr[3:0]] <= shreg;
								page_vld[ptr[3:0]] <= 1'b1;
								ptr[3:0] <= ptr[3:0] + 4'h1;
								pending <= 1'b1;
							end
						end
						eeprom_pkg::st_read: begin
							oe <= 1'b0;
							ptr <= ptr + 9'h001;
						end
						eeprom_pkg::st_idle: begin
						end
					endcase
				end else if (cnt == eeprom_pkg::ACK_BIT) begin
					cnt <= 4'h0;
					oe <= 1'b0;
					unique case (state)
						eeprom_pkg::st_addr: begin
							if (rw) begin
								state <= eeprom_pkg::st_read;
								tx <= mem[ptr];
								oe <= !mem[ptr][7];
							end else begin
								state <= eeprom_pkg::st_word;
							end
						end
						eeprom_pkg::st_word: begin
							state <= eeprom_pkg::st_data;
							wp_lat <= wp_s;
						end
						eeprom_pkg::st_data: begin
						end
						eeprom_pkg::st_read: begin
							if (nack) begin
								state <= eeprom_pkg::st_idle;
							end else begin
								tx <= mem[ptr];
								oe <= !mem[ptr][7];
							end
						end
						eeprom_pkg::st_idle: begin
						end
					endcase
				end else if (state == eeprom_pkg::st_read) begin
					oe <= !tx[3'(4'h7 - cnt)];
				end
			end
		end
	end

	// ----------------------------------------
	// nonvolatile commit
	// ----------------------------------------
	// every buffered byte of the page lands at once; the busy window below only models the delay
	always_ff @(posedge aclk) begin
		if (commit) begin
			for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
				if (page_vld[i]) begin
					mem[{ptr[8:4], 4'(i)}] <= page_buf[i];
				end
			end
		end
	end

	logic [eeprom_pkg::WRITE_TIMER_W-1:0] timer;

	always_ff @(posedge aclk) begin
		if (in_reset) begin
			busy <= 1'b0;
			timer <= '0;
		end else if (commit) begin
			busy <= 1'b1;
			timer <= eeprom_pkg::WRITE_TIMER_W'(WRITE_CYCLES - 1);
		end else if (busy) begin
			if (timer == '0) begin
				busy <= 1'b0;
			end else begin
				timer <= timer - 1'b1;
			end
		end
	end

	assign bus.dev_sda_oe = oe;
	assign write_busy = busy;

endmodule // eeprom_slave

// >>> sync2.sv
/*
 * two-flop synchroniser for a bundle of independent levels.
 * assumes each bit is a slow level; no bundle coherency is offered.
 */
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule // sync2

// >>> test_i2c_serial_eeprom_slave.sv
/* self-checking bench: controller and eeprom joined on one link.
   assumes the design package, interface and both ends compiled first. */
`timescale 1ns/1ps
module test_i2c_serial_eeprom_slave;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	localparam int unsigned WCYC = 5000;
	logic aclk = 0, aresetn = 0, supply_ok = 1, wp = 0, chip_select_low_pin = 0, chip_select_high_pin = 0;
	logic [7:0] awaddr = 8'h0, araddr = 8'h0, rnd = 8'h45, d0, d1;
	logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
	logic [31:0] wdata = 32'h0, rdata, last_rd;
	logic awready, wready, bvalid, arready, rvalid, write_busy;
	logic [1:0] bresp, rresp;
	logic [33:0] note;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [31:0] mq[$];
	int error_cnt = 0, compares = 0, n;
	two_wire_if link();
	bus_master_ctrl bus_master_ctrl_i(.aclk(aclk), .aresetn(aresetn), .bus(link.master), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	eeprom_slave #(.WRITE_CYCLES(WCYC)) eeprom_slave_i(.aclk(aclk), .aresetn(aresetn), .bus(link.slave),
		.supply_ok(supply_ok), .wp(wp), .chip_select_low_pin(chip_select_low_pin),
		.chip_select_high_pin(chip_select_high_pin), .write_busy(write_busy));
	eeprom_link_chk #(.WRITE_CYCLES(WCYC)) eeprom_link_chk_i(.aclk(aclk), .aresetn(aresetn), .scl(link.scl),
		.host_sda_oe(link.host_sda_oe), .dev_sda_oe(link.dev_sda_oe), .sda(link.sda), .supply_ok(supply_ok),
		.write_busy(write_busy));
	initial forever #2 aclk = ~aclk;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction
	function automatic logic [7:0] adr(input logic a8, input logic rw);
		return {eeprom_pkg::TYPE_CODE, chip_select_high_pin, chip_select_low_pin, a8, rw};
	endfunction
	task automatic check_data(input string what, input logic [31:0] exp, got, mask);
		if (mask === 32'h0) return;
		compares++;
		if ((got & mask) !== (exp & mask)) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp & mask, got & mask);
		end
	endtask
	task automatic check_resp(input string what, input logic [1:0] exp, got);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	// bready and rready stay high: every answer is taken at the edge it appears
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = eeprom_pkg::RESP_OKAY);
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] r = eeprom_pkg::RESP_OKAY);
		rq.push_back({r, e});
		mq.push_back(m);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		last_rd = rdata;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 4000; i++) begin
			axi_rd(eeprom_pkg::STATUS_OFFSET, 32'h0, 32'h0);
			if (last_rd[eeprom_pkg::STATUS_BUSY] === 1'b0) return;
		end
		error_cnt++;
		finish_test();
	endtask
	// cmd bits: 0 start, 1 stop, 2 write byte, 3 read byte, 4 nack
	task automatic xfer(input logic [7:0] tx, input logic [4:0] cmd, input logic ack);
		axi_wr(eeprom_pkg::TX_OFFSET, {24'h0, tx});
		axi_wr(eeprom_pkg::CMD_OFFSET, {27'h0, cmd});
		wait_idle();
		axi_rd(eeprom_pkg::STATUS_OFFSET, {30'h0, ack, 1'b0}, 32'h2);
	endtask
	task automatic rd_byte(input logic [4:0] cmd, input logic [7:0] exp);
		axi_wr(eeprom_pkg::CMD_OFFSET, {27'h0, cmd});
		wait_idle();
		axi_rd(eeprom_pkg::RX_OFFSET, {24'h0, exp}, 32'hff);
	endtask
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------
	// result watcher
	// ----------------------------------------
	always @(posedge aclk) begin
		if (bvalid && bready) check_resp("bresp", bq.pop_front(), bresp);
		if (rvalid && rready) begin
			note = rq.pop_front();
			check_resp("rresp", note[33:32], rresp);
			check_data("rdata", note[31:0], rdata, mq.pop_front());
		end
	end
	initial begin
		// about 300 us of link traffic is expected; the margin covers the busy wait
		#380000;
		error_cnt++;
		finish_test();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rnd = lfsr(rnd);
		{chip_select_high_pin, chip_select_low_pin} <= rnd[1:0];
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		axi_wr(8'h40, 32'h0, eeprom_pkg::RESP_SLVERR);
		axi_rd(8'h40, 32'h0, 32'hffffffff, eeprom_pkg::RESP_SLVERR);
		$display("test registers done");
		xfer(adr(0, 0), 5'h05, 1'b1);
		xfer(8'h1f, 5'h04, 1'b1);
		xfer(adr(0, 1), 5'h05, 1'b1);
		rd_byte(5'h1a, eeprom_pkg::ERASED);
		$display("test delivered state done");
		rnd = lfsr(rnd);
		d0 = rnd;
		rnd = lfsr(rnd);
		d1 = rnd;
		xfer(adr(0, 0), 5'h05, 1'b1);
		xfer(8'h1f, 5'h04, 1'b1);
		xfer(d0, 5'h04, 1'b1);
		xfer(d1, 5'h06, 1'b1);
		xfer(adr(0, 0), 5'h07, 1'b0);
		for (n = 0; n < WCYC && write_busy; n++) @(posedge aclk);
		xfer(adr(0, 0), 5'h05, 1'b1);
		xfer(8'h1f, 5'h04, 1'b1);
		xfer(adr(0, 1), 5'h05, 1'b1);
		rd_byte(5'h08, d0);
		rd_byte(5'h1a, eeprom_pkg::ERASED);
		xfer(adr(0, 0), 5'h05, 1'b1);
		xfer(8'h10, 5'h04, 1'b1);
		xfer(adr(0, 1), 5'h05, 1'b1);
		rd_byte(5'h1a, d1);
		// the upper address bit picks the other half: same byte address, still erased
		xfer(adr(1, 0), 5'h05, 1'b1);
		xfer(8'h1f, 5'h04, 1'b1);
		xfer(adr(1, 1), 5'h05, 1'b1);
		rd_byte(5'h1a, eeprom_pkg::ERASED);
		$display("test page write done");
		wp <= 1'b1;
		xfer(adr(0, 0), 5'h05, 1'b1);
		xfer(8'h30, 5'h04, 1'b1);
		xfer(d0, 5'h06, 1'b0);
		check_data("write_busy", 32'h0, {31'h0, write_busy}, 32'h1);
		wp <= 1'b0;
		$display("test write protect done");
		xfer({eeprom_pkg::TYPE_CODE, ~chip_select_high_pin, chip_select_low_pin, 2'b00}, 5'h07, 1'b0);
		xfer({4'hb, chip_select_high_pin, chip_select_low_pin, 2'b00}, 5'h07, 1'b0);
		supply_ok <= 1'b0;
		repeat (8) @(posedge aclk);
		supply_ok <= 1'b1;
		repeat (8) @(posedge aclk);
		xfer(adr(0, 1), 5'h05, 1'b1);
		rd_byte(5'h1a, eeprom_pkg::ERASED);
		$display("test addressing and supply done");
		finish_test();
	end
endmodule // test_i2c_serial_eeprom_slave

// >>> two_wire_if.sv
/*
 * the two-wire bus joining master and eeprom.
 * assumes pull-ups: sda is high unless one end enables its driver.
 */
`timescale 1ns/1ps
interface two_wire_if;
	logic scl;
	logic host_sda_oe;
	logic dev_sda_oe;
	logic sda;

	// open drain: any enabled driver pulls low
	assign sda = !(host_sda_oe || dev_sda_oe);

	modport master(output scl, output host_sda_oe, input sda);
	modport slave(input scl, output dev_sda_oe, input sda);
endinterface
